// ---- sim/acv_chk.sv ----
// checker
module acv_chk #(parameter int CONV_CYC = 3) (input wire logic i_mclk, i_rst, i_cs_n, i_sample_hold, i_rd_n, i_oe,
	input wire logic i_interface_mode_select, o_eoc_n, o_ready_n, o_standby, input wire logic [11:0] o_data_oe);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// eoc stays low from the edge after the take through the edge that brings the result
	localparam int EOC_LOW = CONV_CYC + 1;
	sequence s_go; !i_cs_n && $fell(i_sample_hold) && o_eoc_n; endsequence
	property p_go; s_go ##0 !o_standby |=> !o_eoc_n; endproperty
	a_go: assert property (p_go) else $error("go");
	property p_sb; s_go ##0 o_standby |=> o_eoc_n; endproperty
	a_sb: assert property (p_sb) else $error("sb");
	property p_ln; $fell(o_eoc_n) |-> ##EOC_LOW $rose(o_eoc_n); endproperty
	a_ln: assert property (p_ln) else $error("ln");
	property p_dn; $rose(o_eoc_n) && !i_interface_mode_select |-> !o_ready_n; endproperty
	a_dn: assert property (p_dn) else $error("dn");
	property p_hs; $rose(o_eoc_n) && i_interface_mode_select |-> o_ready_n; endproperty
	a_hs: assert property (p_hs) else $error("hs");
	property p_rd; $fell(i_rd_n) && !i_cs_n && o_eoc_n |=> o_ready_n; endproperty
	a_rd: assert property (p_rd) else $error("rd");
	property p_on; i_oe && !i_cs_n && !i_rd_n && o_eoc_n |=> &o_data_oe; endproperty
	a_on: assert property (p_on) else $error("on");
	property p_of; !i_oe |=> !o_data_oe; endproperty
	a_of: assert property (p_of) else $error("of");
endmodule // acv_chk
bind acv_top acv_chk #(.CONV_CYC(CONV_CYC)) u_chk (.*);

// ---- sim/acv_host.sv ----
// host strobe model
module acv_host (input wire logic i_mclk, input wire logic i_go, output logic o_sh);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] n = 2'h0;
	// a two-cycle low pulse stays below half of any sample period used here
	assign o_sh = n == 2'h0;
	always @(negedge i_mclk) n <= i_go ? 2'h2 : n - 2'(n != 2'h0);
endmodule // acv_host

// ---- sim/acv_tb.sv ----
// bench
module adc_conversion_host_interface_tb_top import acv_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk = 1'h0, i_rst = 1'h1, i_cs_n = 1'h0, i_rd_n = 1'h1, i_oe = 1'h1, i_chan_sel = 1'h0, go = 1'h0;
	logic i_interface_mode_select = 1'h0, i_standby_request_n = 1'h1, i_sample_hold, o_eoc_n, o_ready_n, o_standby;
	logic [ACV_DATA_W-1:0] o_data, o_data_oe, i_ch1_sample = 12'hA5C, i_ch2_sample = 12'h3E1;
	int n_errors = 0, tests_run = 0;
	acv_host u_host (.i_mclk, .i_go(go), .o_sh(i_sample_hold));
	acv_top #(.CONV_CYC(3)) dut (.*);
	task automatic chk(input logic [13:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic pulse();
		go <= 1'h1;
		@(negedge i_mclk);
		go <= 1'h0;
		repeat (3) @(negedge i_mclk);
	endtask
	task automatic conv(input logic ch, md);
		i_chan_sel <= ch;
		i_interface_mode_select <= md;
		pulse();
		repeat (2) @(negedge i_mclk);
		chk({o_eoc_n, o_ready_n, o_data}, {1'h1, md, ch ? i_ch2_sample : i_ch1_sample});
		// read before the next conversion can overwrite the latch
		i_rd_n <= 1'h0;
		@(negedge i_mclk);
		chk({1'h0, o_ready_n, o_data_oe}, 14'h1FFF);
		i_rd_n <= 1'h1;
	endtask
	task automatic idle();
		i_standby_request_n <= 1'h0;
		i_oe <= 1'h0;
		pulse();
		chk({o_eoc_n, o_standby, o_data_oe}, 14'h3000);
		i_standby_request_n <= 1'h1;
		i_oe <= 1'h1;
		@(negedge i_mclk);
	endtask
	task automatic desel();
		i_cs_n <= 1'h1;
		pulse();
		chk({o_eoc_n, o_standby, o_data_oe}, 14'h2000);
		i_cs_n <= 1'h0;
		@(negedge i_mclk);
	endtask
	initial forever #12.5 i_mclk = ~i_mclk;
	initial begin
		repeat (3) @(negedge i_mclk);
		i_rst <= 1'h0;
		conv(1'h0, 1'h0);
		conv(1'h1, 1'h1);
		idle();
		desel();
		test_done();
	end
	initial begin
		#5us;
		n_errors++;
		test_done();
	end
endmodule // adc_conversion_host_interface_tb_top

// ---- src/acv_core.sv ----
// conversion timer core: counts the conversion and produces a result
module acv_core
	import acv_pkg::*;
#(
	parameter int CONV_CYC = ACV_CONV_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_chan,
	input wire logic [ACV_DATA_W-1:0] i_ch1_sample,
	input wire logic [ACV_DATA_W-1:0] i_ch2_sample,
	output logic o_busy,
	output logic o_done,
	output logic [ACV_DATA_W-1:0] o_result
);
	initial begin
		if (CONV_CYC < 1 || CONV_CYC > 65535) $error("conversion count out of range");
	end
	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
		logic done;
		logic [ACV_DATA_W-1:0] held;
		logic [ACV_DATA_W-1:0] result;
	} acv_core_st_t;
	acv_core_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (i_start && !st_reg.busy) begin
			// freeze the selected input at the start
			st_next.held = i_chan ? i_ch2_sample : i_ch1_sample; // [RQ11]
			st_next.busy = 1'b1;
			st_next.cnt = 16'(CONV_CYC - 1);
		end else if (st_reg.busy) begin
			if (st_reg.cnt == 16'h0000) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
				st_next.result = st_reg.held;
			end else begin
				st_next.cnt = st_reg.cnt - 16'h0001;
			end
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_busy = st_reg.busy;
	assign o_done = st_reg.done;
	assign o_result = st_reg.result;
endmodule // acv_core

// ---- src/acv_pkg.sv ----
// package of constants for the conversion control and read-out block
// Function
// [RQ1] chip select low: strobe fall starts conversion
// [RQ2] conversion end: done high, ready low
// [RQ3] notify mode: ready low means latched, host reads
// [RQ4] read strobe fall returns ready high
// [RQ5] transparent mode: data always present, no handshake
// [RQ6] exactly two modes: notify and transparent
// [RQ7] host keeps slow-rate strobe pulse under half period
// [RQ8] host drives strobe as clean square wave; the host model drives a two-cycle low pulse instead
// [RQ9] done flag low throughout each conversion
// [RQ10] data driven only when enable, select, read
// [RQ11] channel choice sampled when done flag falls
// [RQ12] standby request low puts converter in standby
// [RQ13] host reads each result before next overwrites
package acv_pkg;
	// ****************************************
	// widths and timing
	// ****************************************
	localparam int ACV_DATA_W = 12;
	localparam int ACV_CLK_HZ = 40000000;
	localparam int ACV_CONV_NS = 600;
	localparam int ACV_CONV_CYC = (ACV_CONV_NS * (ACV_CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [ACV_DATA_W-1:0] ACV_RESULT_RST = 12'h000;
	// ****************************************
	// modes and states
	// ****************************************
	typedef enum logic {ACV_MODE_NOTIFY, ACV_MODE_TRANSPARENT} acv_mode_t;
	typedef enum logic [1:0] {ACV_IDLE, ACV_CONVERT, ACV_STANDBY} acv_state_t;
endpackage : acv_pkg

// ---- src/acv_top.sv ----
// top of conversion control and parallel read-out
module acv_top
	import acv_pkg::*;
#(
	parameter int CONV_CYC = ACV_CONV_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_cs_n,
	input wire logic i_sample_hold,
	input wire logic i_rd_n,
	input wire logic i_oe,
	input wire logic i_chan_sel,
	input wire logic i_interface_mode_select,
	input wire logic i_standby_request_n,
	input wire logic [ACV_DATA_W-1:0] i_ch1_sample,
	input wire logic [ACV_DATA_W-1:0] i_ch2_sample,
	output logic o_eoc_n,
	output logic o_ready_n,
	output logic o_standby,
	output logic [ACV_DATA_W-1:0] o_data,
	output logic [ACV_DATA_W-1:0] o_data_oe
);
	typedef struct packed {
		logic sh_d;
		logic rd_d;
		logic eoc_n;
		logic ready_n;
		logic standby;
		logic [ACV_DATA_W-1:0] latch;
		logic [ACV_DATA_W-1:0] data;
		logic [ACV_DATA_W-1:0] data_oe;
	} acv_top_st_t;
	acv_top_st_t st_reg, st_next;
	logic start;
	logic busy;
	logic done;
	logic [ACV_DATA_W-1:0] result;
	acv_mode_t mode;
	// ****************************************
	// conversion start
	// ****************************************
	assign mode = acv_mode_t'(i_interface_mode_select); // [RQ6]
	// standby blocks new conversions; a running one is let finish
	assign start = !i_cs_n && st_reg.sh_d && !i_sample_hold && !st_reg.standby; // [RQ1]
	acv_core #(
		.CONV_CYC(CONV_CYC)
	) u_core (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_start(start),
		.i_chan(i_chan_sel),
		.i_ch1_sample(i_ch1_sample),
		.i_ch2_sample(i_ch2_sample),
		.o_busy(busy),
		.o_done(done),
		.o_result(result)
	);
	// ****************************************
	// handshake and bus
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.sh_d = i_sample_hold;
		st_next.rd_d = i_rd_n;
		st_next.standby = !i_standby_request_n; // [RQ12]
		st_next.eoc_n = !(busy || start); // [RQ9]
		// read low while selected clears ready, fall or held; a completion in the same cycle wins
		if (!i_cs_n && st_reg.rd_d && !i_rd_n) begin
			st_next.ready_n = 1'b1; // [RQ4]
		end
		if (!i_rd_n && !i_cs_n) begin
			st_next.ready_n = 1'b1;
		end
		if (done) begin
			st_next.latch = result;
			st_next.eoc_n = 1'b1; // [RQ2]
			if (mode == ACV_MODE_NOTIFY) begin
				st_next.ready_n = 1'b0; // [RQ2] [RQ3]
			end
		end
		if (mode == ACV_MODE_TRANSPARENT) begin
			st_next.ready_n = 1'b1; // [RQ5]
		end
		st_next.data = done ? result : st_reg.latch; // [RQ5]
		st_next.data_oe = (i_oe && !i_cs_n && !i_rd_n) ? {ACV_DATA_W{1'b1}} : '0; // [RQ10]
	end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.sh_d <= 1'b1;
			st_reg.rd_d <= 1'b1;
			st_reg.eoc_n <= 1'b1;
			st_reg.ready_n <= 1'b1;
			st_reg.latch <= ACV_RESULT_RST;
			st_reg.data <= ACV_RESULT_RST;
		end else begin
			st_reg <= st_next;
		end
	end
	assign o_eoc_n = st_reg.eoc_n;
	assign o_ready_n = st_reg.ready_n;
	assign o_standby = st_reg.standby;
	assign o_data = st_reg.data;
	assign o_data_oe = st_reg.data_oe;
endmodule // acv_top
